// ---- design/tcc_regs.svh ----
// Register map, field positions, reset values and timing counts for the
// timer counter and channel control block. Definitions only.
// Functional notes
// [R1] Main timer is a 16-bit up counter, zero after reset.
// [R2] Counter reads anytime; writes load it only while test mode is high.
// [R3] Whole counter word is read or loaded in one access cycle.
// [R4] First period after a counter write may be short or long.
// [R5] Enable bit clear stops the whole timer; set runs it normally.
// [R6] No divide-by-64 tick to pulse accumulators while timer inactive.
// [R7] Halt-in-wait stops timer, accumulators, modulus counter during wait.
// [R8] Halt-in-freeze stops timer and modulus counter, not accumulators.
// [R9] Fast clear: capture read or compare write at 0x10-0x1F clears flag.
// [R10] Fast clear: any counter access clears the overflow flag.
// [R11] Fast clear: pulse counts 3/2 clear accumulator A, 1/0 clear B.
// [R12] Toggle-on-overflow inverts a compare channel pin on counter wrap.
// [R13] Overflow toggle beats forced compare, yields to channel 7 override.
// [R14] Action code: 00 off, 01 toggle, 10 drive low, 11 drive high.
// [R15] Nonzero action, compare mode and enable make pin a driven output.
// [R16] Software clears channel's ch7 mask bit so action code owns pin.
// [R17] Software sets compare, action 00, mask clear for wide accumulators.
// [R18] Edge code: 00 off, 01 rising, 10 falling, 11 both edges.
// [R19] Channel 0-3 edge codes also steer the narrow and B accumulators.
// [R20] Interrupt enable bit gates channel flag at same bit position.
// [R21] Direction bit zero means capture, one means compare.
// [R22] Overflow flag sets when counter wraps from all ones to zero.
// [R23] Counter steps once per prescaled tick only while running.
`ifndef TCC_REGS_SVH
`define TCC_REGS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define TCC_IDX_DIR      6'h00
`define TCC_IDX_MASK7    6'h02
`define TCC_IDX_CNT      6'h04
`define TCC_IDX_CNT_LO   6'h05
`define TCC_IDX_SYSCTL   6'h06
`define TCC_IDX_TOV      6'h07
`define TCC_IDX_ACT74    6'h08
`define TCC_IDX_ACT30    6'h09
`define TCC_IDX_EDG74    6'h0a
`define TCC_IDX_EDG30    6'h0b
`define TCC_IDX_IEN      6'h0c
`define TCC_IDX_CFLG     6'h0e
`define TCC_IDX_OFLG     6'h0f
`define TCC_IDX_CC_LO    6'h10
`define TCC_IDX_CC_HI    6'h1f
`define TCC_IDX_PC3      6'h22
`define TCC_IDX_PC2      6'h23
`define TCC_IDX_PC1      6'h24
`define TCC_IDX_PC0      6'h25

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define TCC_SC_RUN       7
`define TCC_SC_WAIT      6
`define TCC_SC_FRZ       5
`define TCC_SC_FFC       4
`define TCC_OFLG_BIT     7
`define TCC_RST8         8'h00
`define TCC_RST16        16'h0000
`define TCC_CNT_MAX      16'hffff

// ----------------------------------------------------------------
// Prescaler
// ----------------------------------------------------------------
`define TCC_PRE_MASK     7'h00
`define TCC_DIV64_MASK   7'h3f
`endif

// ---- design/tcc_pkg.sv ----
// Types shared by the timer counter and channel control block.
// Assumes the register header is compiled alongside.
package tcc_pkg;
   // Compare action code per channel
   typedef enum logic [1:0] {
      ACT_OFF,
      ACT_TOGGLE,
      ACT_LOW,
      ACT_HIGH
   } tcc_action_t;

   // Capture edge code per channel
   typedef enum logic [1:0] {
      EDG_OFF,
      EDG_RISE,
      EDG_FALL,
      EDG_BOTH
   } tcc_edge_t;
endpackage : tcc_pkg

// ---- design/tcc_edge_detect.sv ----
// Edge detector for one timer channel input.
// Assumes the level is already synchronised to ref_clk.
module tcc_edge_detect
   import tcc_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // Channel
   input  wire logic        level,
   input  wire tcc_edge_t   edgeCode,
   output logic             edgeHit
);
   logic prev_r;

   // Previous sample for edge comparison
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         prev_r <= 1'b0;
      else
         prev_r <= level;
   end

   // Edge selection by code
   always_comb
   begin
      case (edgeCode)
         EDG_RISE: edgeHit = level & ~prev_r;  // R18
         EDG_FALL: edgeHit = ~level & prev_r;  // R18
         EDG_BOTH: edgeHit = level ^ prev_r;   // R18
         default:  edgeHit = 1'b0;
      endcase
   end
endmodule : tcc_edge_detect

// ---- design/tcc_top.sv ----
// Main timer counter, system control and per-channel pin control.
// Assumes an APB master on ref_clk, compare hits and forces from the
// neighbouring comparator logic on ref_clk, and raw timer port pins.
`include "tcc_regs.svh"
module tcc_top
   import tcc_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Chip mode pins
   input  wire logic        testMode,
   input  wire logic        waitMode,
   input  wire logic        freezeMode,
   // Comparator side, same clock
   input  wire logic [7:0]  cmpHit,
   input  wire logic [7:0]  cmpForce,
   input  wire logic [7:0]  ch7OvrData,
   // Timer port pins
   input  wire logic [7:0]  pinIn,
   output logic [7:0]       pinOut,
   output logic [7:0]       pinOe,
   // Neighbour control
   output logic             tick64,
   output logic             accumRun,
   output logic             modDownRun,
   output logic [3:0]       narrowEdge,
   output logic             clrAccumA,
   output logic             clrAccumB,
   // Status
   output logic [7:0]       chanIrq,
   output logic             overflowFlag
);
   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [10:0] syncMeta_r;
   logic [10:0] syncOut_r;
   logic [7:0]  dir_r;
   logic [7:0]  mask7_r;
   logic [15:0] cnt_r;
   logic [7:0]  sysCtl_r;
   logic [7:0]  tov_r;
   logic [15:0] action_r;
   logic [15:0] edgeSel_r;
   logic [7:0]  ien_r;
   logic [7:0]  chanFlag_r;
   logic        ovfFlag_r;
   logic [6:0]  pre_r;
   logic [31:0] rdata_r;
   logic        err_r;
   logic        clrA_r;
   logic        clrB_r;
   logic [7:0]  pinOut_r;
   logic [7:0]  edgeHit;
   logic [7:0]  pinSync;
   logic        tstSync;
   logic        waitSync;
   logic        frzSync;
   logic        acc;
   logic        wr;
   logic        rd;
   logic [5:0]  idx;
   logic        mapped;
   logic        inCc;
   logic [2:0]  ccChan;
   logic        active;
   logic        cntTick;
   logic        cntLoad;
   logic        ovfEvt;
   logic        ovr7;
   logic [7:0]  flagSet;
   logic [7:0]  flagClr;
   logic        cntAcc;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // Second stage alone feeds logic
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         syncMeta_r <= 11'h000;
         syncOut_r  <= 11'h000;
      end
      else
      begin
         syncMeta_r <= {testMode, waitMode, freezeMode, pinIn};
         syncOut_r  <= syncMeta_r;
      end
   end

   assign pinSync  = syncOut_r[7:0];
   assign frzSync  = syncOut_r[8];
   assign waitSync = syncOut_r[9];
   assign tstSync  = syncOut_r[10];

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   assign acc    = psel & penable;
   assign wr     = acc & pwrite;
   assign rd     = acc & ~pwrite;
   assign idx    = paddr[7:2];
   assign inCc   = (idx >= `TCC_IDX_CC_LO) && (idx <= `TCC_IDX_CC_HI);
   assign ccChan = idx[3:1];
   assign cntAcc = acc && ((idx == `TCC_IDX_CNT) || (idx == `TCC_IDX_CNT_LO));

   // Address map check; misaligned counts as unmapped
   always_comb
   begin
      if (paddr[1:0] != 2'b00)
         mapped = 1'b0;
      else if (idx == `TCC_IDX_DIR || idx == `TCC_IDX_MASK7)
         mapped = 1'b1;
      else if (idx >= `TCC_IDX_CNT && idx <= `TCC_IDX_IEN)
         mapped = 1'b1;
      else if (idx >= `TCC_IDX_CFLG && idx <= `TCC_IDX_CC_HI)
         mapped = 1'b1;
      else if (idx >= `TCC_IDX_PC3 && idx <= `TCC_IDX_PC0)
         mapped = 1'b1;
      else
         mapped = 1'b0;
   end

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   // Writes land only at the access edge; unmapped writes are dropped
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         dir_r     <= `TCC_RST8;
         mask7_r   <= `TCC_RST8;
         sysCtl_r  <= `TCC_RST8;
         tov_r     <= `TCC_RST8;
         action_r  <= `TCC_RST16;
         edgeSel_r <= `TCC_RST16;
         ien_r     <= `TCC_RST8;
      end
      else if (wr && paddr[1:0] == 2'b00)
      begin
         if (idx == `TCC_IDX_DIR)
            dir_r <= pwdata[7:0];
         else if (idx == `TCC_IDX_MASK7)
            mask7_r <= pwdata[7:0];
         else if (idx == `TCC_IDX_SYSCTL)
            sysCtl_r <= {pwdata[7:4], 4'h0};
         else if (idx == `TCC_IDX_TOV)
            tov_r <= pwdata[7:0];
         else if (idx == `TCC_IDX_ACT74)
            action_r[15:8] <= pwdata[7:0];
         else if (idx == `TCC_IDX_ACT30)
            action_r[7:0] <= pwdata[7:0];
         else if (idx == `TCC_IDX_EDG74)
            edgeSel_r[15:8] <= pwdata[7:0];
         else if (idx == `TCC_IDX_EDG30)
            edgeSel_r[7:0] <= pwdata[7:0];
         else if (idx == `TCC_IDX_IEN)
            ien_r <= pwdata[7:0];
      end
   end

   // ----------------------------------------------------------------
   // Run conditions and prescaler
   // ----------------------------------------------------------------
   assign active = sysCtl_r[`TCC_SC_RUN]                    // R5
                 & ~(sysCtl_r[`TCC_SC_WAIT] & waitSync)      // R7
                 & ~(sysCtl_r[`TCC_SC_FRZ] & frzSync);       // R8
   assign accumRun   = ~(sysCtl_r[`TCC_SC_WAIT] & waitSync); // R7 R8
   assign modDownRun = active;                               // R7 R8

   // Prescaler runs only while active, never cleared by a counter write
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         pre_r <= 7'h00;
      else if (active)
         pre_r <= pre_r + 7'h01;
   end

   assign cntTick = active                                   // R23
                  && ((pre_r & `TCC_PRE_MASK) == `TCC_PRE_MASK);
   assign tick64  = active                                   // R6
                  && ((pre_r & `TCC_DIV64_MASK) == `TCC_DIV64_MASK);

   // ----------------------------------------------------------------
   // Main counter
   // ----------------------------------------------------------------
   // Word load in one access; not aligned to the prescaler tick
   assign cntLoad = wr && (idx == `TCC_IDX_CNT) && tstSync;  // R2 R3 R4
   assign ovfEvt  = cntTick && !cntLoad && (cnt_r == `TCC_CNT_MAX);

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         cnt_r <= `TCC_RST16;                                // R1
      else if (cntLoad)
         cnt_r <= pwdata[15:0];                              // R2
      else if (cntTick)
         cnt_r <= cnt_r + 16'h0001;                          // R1 R23
   end

   // ----------------------------------------------------------------
   // Flags
   // ----------------------------------------------------------------
   // Capture on edge in capture mode, compare hit unless forced
   assign flagSet = (edgeHit & ~dir_r)                       // R21
                  | (cmpHit & ~cmpForce & dir_r);

   // Write-one clear plus fast clear by value register access
   always_comb
   begin
      flagClr = 8'h00;
      if (wr && idx == `TCC_IDX_CFLG)
         flagClr = pwdata[7:0];
      if (sysCtl_r[`TCC_SC_FFC] && inCc)
      begin
         if ((rd && !dir_r[ccChan]) || (wr && dir_r[ccChan]))
            flagClr[ccChan] = 1'b1;                          // R9
      end
   end

   // Set wins over a clear in the same cycle
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         chanFlag_r <= `TCC_RST8;
      else
         chanFlag_r <= (chanFlag_r & ~flagClr) | flagSet;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         ovfFlag_r <= 1'b0;
      else if (ovfEvt)
         ovfFlag_r <= 1'b1;                                  // R22
      else if (sysCtl_r[`TCC_SC_FFC] && cntAcc)
         ovfFlag_r <= 1'b0;                                  // R10
      else if (wr && idx == `TCC_IDX_OFLG && pwdata[`TCC_OFLG_BIT])
         ovfFlag_r <= 1'b0;
   end

   // Accumulator flag clears, one-cycle pulses to the neighbours
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         clrA_r <= 1'b0;
         clrB_r <= 1'b0;
      end
      else
      begin
         clrA_r <= acc && sysCtl_r[`TCC_SC_FFC]              // R11
                && (idx == `TCC_IDX_PC3 || idx == `TCC_IDX_PC2);
         clrB_r <= acc && sysCtl_r[`TCC_SC_FFC]              // R11
                && (idx == `TCC_IDX_PC1 || idx == `TCC_IDX_PC0);
      end
   end

   assign chanIrq      = chanFlag_r & ien_r;                 // R20
   assign overflowFlag = ovfFlag_r;
   assign clrAccumA    = clrA_r;
   assign clrAccumB    = clrB_r;
   assign narrowEdge   = edgeHit[3:0];                       // R19

   // ----------------------------------------------------------------
   // Channels
   // ----------------------------------------------------------------
   // Channel 7 compare overrides masked pins
   assign ovr7 = cmpHit[7] & dir_r[7];

   genvar g;
   generate
      for (g = 0; g < 8; g++)
      begin : gChan
         tcc_action_t act;
         logic        actNxt;

         assign act = tcc_action_t'(action_r[2*g+1 -: 2]);

         tcc_edge_detect uEdge (
            .ref_clk  (ref_clk),
            .rst      (rst),
            .level    (pinSync[g]),
            .edgeCode (tcc_edge_t'(edgeSel_r[2*g+1 -: 2])),  // R18 R19
            .edgeHit  (edgeHit[g])
         );

         // Action taken on a compare or a forced compare
         always_comb
         begin
            case (act)
               ACT_TOGGLE: actNxt = ~pinOut_r[g];            // R14
               ACT_LOW:    actNxt = 1'b0;                    // R14
               ACT_HIGH:   actNxt = 1'b1;                    // R14
               default:    actNxt = pinOut_r[g];             // R14
            endcase
         end

         // Override, then overflow toggle, then compare action
         always_ff @(posedge ref_clk or posedge rst)
         begin
            if (rst)
               pinOut_r[g] <= 1'b0;
            else if (ovr7 && mask7_r[g])
               pinOut_r[g] <= ch7OvrData[g];                 // R13
            else if (ovfEvt && tov_r[g] && dir_r[g])
               pinOut_r[g] <= ~pinOut_r[g];                  // R12 R13
            else if (dir_r[g] && (cmpHit[g] || cmpForce[g]))
               pinOut_r[g] <= actNxt;
         end

         // Pin drive: action or ch7 mask, compare mode, timer on
         assign pinOe[g] = dir_r[g] && sysCtl_r[`TCC_SC_RUN] // R15
                         && (act != ACT_OFF || mask7_r[g]);  // R16
      end
   endgenerate

   assign pinOut = pinOut_r;

   // ----------------------------------------------------------------
   // Read data and answer
   // ----------------------------------------------------------------
   // Captured in the setup cycle so data comes from flops
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         rdata_r <= 32'h0000_0000;
         err_r   <= 1'b0;
      end
      else if (psel && !penable)
      begin
         err_r   <= ~mapped;
         rdata_r <= 32'h0000_0000;
         if (!mapped || pwrite)
            rdata_r <= 32'h0000_0000;
         else if (idx == `TCC_IDX_DIR)
            rdata_r[7:0] <= dir_r;
         else if (idx == `TCC_IDX_MASK7)
            rdata_r[7:0] <= mask7_r;
         else if (idx == `TCC_IDX_CNT)
            rdata_r[15:0] <= cnt_r;                          // R2 R3
         else if (idx == `TCC_IDX_SYSCTL)
            rdata_r[7:0] <= sysCtl_r;
         else if (idx == `TCC_IDX_TOV)
            rdata_r[7:0] <= tov_r;
         else if (idx == `TCC_IDX_ACT74)
            rdata_r[7:0] <= action_r[15:8];
         else if (idx == `TCC_IDX_ACT30)
            rdata_r[7:0] <= action_r[7:0];
         else if (idx == `TCC_IDX_EDG74)
            rdata_r[7:0] <= edgeSel_r[15:8];
         else if (idx == `TCC_IDX_EDG30)
            rdata_r[7:0] <= edgeSel_r[7:0];
         else if (idx == `TCC_IDX_IEN)
            rdata_r[7:0] <= ien_r;
         else if (idx == `TCC_IDX_CFLG)
            rdata_r[7:0] <= chanFlag_r;
         else if (idx == `TCC_IDX_OFLG)
            rdata_r[`TCC_OFLG_BIT] <= ovfFlag_r;
      end
   end

   assign prdata  = rdata_r;
   assign pready  = 1'b1;
   assign pslverr = acc & err_r;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_cnt_step: assert property (cntTick && !cntLoad |=> // R23
      cnt_r == $past(cnt_r) + 16'h0001)
      else $error("counter missed a tick");
   a_cnt_hold: assert property (!active && !cntLoad |=> // R5
      $stable(cnt_r)) else $error("counter moved while stopped");
   a_cnt_nowrite: assert property (wr && idx == `TCC_IDX_CNT // R2
      && !tstSync && !cntTick |=> $stable(cnt_r))
      else $error("counter loaded outside test mode");
   a_ovf_set: assert property (ovfEvt |=> ovfFlag_r // R22
      ##0 cnt_r == 16'h0000) else $error("wrap did not set flag");
   a_tick64_gate: assert property (!active |-> !tick64) // R6
      else $error("div64 tick while inactive");
   a_fast_ovf: assert property (cntAcc && sysCtl_r[`TCC_SC_FFC] // R10
      && !ovfEvt |=> !ovfFlag_r) else $error("fast clear missed");
   a_wait_halt: assert property (sysCtl_r[`TCC_SC_WAIT] // R7
      && waitSync |-> !accumRun && !modDownRun && !cntTick)
      else $error("wait did not halt");
   a_frz_acc: assert property (sysCtl_r[`TCC_SC_FRZ] && frzSync // R8
      && !waitSync |-> accumRun && !cntTick)
      else $error("freeze handling wrong");
   a_irq_gate: assert property (flagSet[0] && ien_r[0] && !wr // R20
      |=> chanIrq[0]) else $error("enabled flag raised no irq");
   a_oe_off: assert property (!sysCtl_r[`TCC_SC_RUN] // R15
      |-> pinOe == 8'h00) else $error("pin driven while off");
   a_tov_toggle: assert property (ovfEvt && tov_r[0] && dir_r[0] // R12
      && !(ovr7 && mask7_r[0]) |=> pinOut_r[0] != $past(pinOut_r[0]))
      else $error("overflow toggle missed");
   a_cap_flag: assert property (edgeHit[1] && !dir_r[1] // R21
      |=> chanFlag_r[1]) else $error("capture flag not set");

   c_overflow: cover property (ovfEvt ##1 ovfFlag_r);
   c_capture: cover property (edgeHit[0] && !dir_r[0]);
   c_fast_clr: cover property (cntAcc && sysCtl_r[`TCC_SC_FFC]);
   c_ovr7: cover property (ovr7 && |mask7_r);
endmodule : tcc_top

// ---- tb/tcc_pin_model.sv ----
// Timer port pins as seen from the board side.
// Assumes the bench sets the level of every pin the block leaves free.
module tcc_pin_model
(
   // Block side
   input  wire logic [7:0] pinOut,
   input  wire logic [7:0] pinOe,
   // Board side
   input  wire logic [7:0] extLevel,
   output logic [7:0]      pinIn
);
   timeunit 1ns;
   timeprecision 100ps;
   // Driven pins follow the block, free pins the board
   assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule : tcc_pin_model

// ---- tb/tcc_top_bench.sv ----
// Self-checking bench for the timer counter and channel control block.
// Assumes the design files and register header are compiled first.
`include "tcc_regs.svh"
module tcc_top_bench;
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------------
   // Signals, counters and register table
   // ----------------------------------------------
   typedef struct {logic [5:0] i; logic [31:0] w, e;} tcc_row_t;
   logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr;
   logic        testMode, waitMode, freezeMode, er, ovf, aRun, mRun;
   logic        t64, clrA;
   logic [7:0]  paddr, cmpHit, frc, ext, pinIn, pinOut, pinOe, irq;
   logic [3:0]  nEdge;
   logic [31:0] pwdata, prdata, rd, a;
   int          tickN, edgeN, clrN, cyc, failures, checkCount, t0;
   tcc_row_t    rows[10] = '{
      '{`TCC_IDX_CNT, 32'h1234, 32'h0}, '{`TCC_IDX_DIR, 32'ha5, 32'ha5},
      '{`TCC_IDX_MASK7, 32'h5a, 32'h5a}, '{`TCC_IDX_TOV, 32'h3c, 32'h3c},
      '{`TCC_IDX_ACT74, 32'hc3, 32'hc3}, '{`TCC_IDX_ACT30, 32'h96, 32'h96},
      '{`TCC_IDX_EDG74, 32'h69, 32'h69}, '{`TCC_IDX_EDG30, 32'h0f, 32'h0f},
      '{`TCC_IDX_IEN, 32'hf0, 32'hf0}, '{`TCC_IDX_SYSCTL, 32'h7f, 32'h70}};

   tcc_top u_tcc_top (.ref_clk(ref_clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .testMode(testMode), .waitMode(waitMode), .freezeMode(freezeMode),
      .cmpHit(cmpHit), .cmpForce(frc), .ch7OvrData(8'h00),
      .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .tick64(t64),
      .accumRun(aRun), .modDownRun(mRun), .narrowEdge(nEdge),
      .clrAccumA(clrA), .clrAccumB(), .chanIrq(irq), .overflowFlag(ovf));
   tcc_pin_model u_tcc_pin_model (.pinOut(pinOut), .pinOe(pinOe),
      .extLevel(ext), .pinIn(pinIn));

   // Clock at 125 MHz
   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   // Pulse counters and hang limit; non-blocking so reads never race
   always @(posedge ref_clk)
   begin
      tickN <= tickN + t64;
      edgeN <= edgeN + nEdge[1];
      clrN  <= clrN + clrA;
      cyc   <= cyc + 1;
      if (cyc == 5000)
      begin
         failures++;
         report_and_stop;
      end
   end

   // Read data and error taken at the completing edge
   always @(posedge ref_clk)
      if (psel && penable && pready)
      begin
         rd <= prdata;
         er <= pslverr;
      end

   // ----------------------------------------------
   // Tasks
   // ----------------------------------------------
   task apb(input logic w, input logic [5:0] i, input logic [31:0] d);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= {i, 2'b00};
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1) @(posedge ref_clk);
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask : apb

   task chk(input logic [31:0] g, input logic [31:0] e);
      checkCount++;
      if (g !== e)
      begin
         failures++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask : chk

   task hit(input logic [7:0] h, input logic [7:0] f);
      cmpHit <= h;
      frc    <= f;
      @(posedge ref_clk);
      cmpHit <= 8'h00;
      frc    <= 8'h00;
      @(posedge ref_clk);
   endtask : hit

   task report_and_stop;
      $display("checks %0d mismatches %0d", checkCount, failures);
      if (failures == 0 && checkCount > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : report_and_stop

   // ----------------------------------------------
   // Main sequence
   // ----------------------------------------------
   initial
   begin
      {rst, psel, penable, pwrite, testMode, waitMode} = 6'h20;
      {freezeMode, paddr, pwdata, cmpHit, frc, ext} = 0;
      {tickN, edgeN, clrN, cyc, failures, checkCount} = 0;
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      foreach (rows[k])
      begin
         apb(1'b1, rows[k].i, rows[k].w);
         apb(1'b0, rows[k].i, 32'h0);
         chk(rd, rows[k].e);
      end
      apb(1'b0, 6'h3f, 32'h0);
      chk({rd[30:0], er}, 32'h1);
      // Channel 0 compare actions, mask cleared so codes own the pin
      apb(1'b1, `TCC_IDX_DIR, 32'h01);
      apb(1'b1, `TCC_IDX_MASK7, 32'h0);
      apb(1'b1, `TCC_IDX_TOV, 32'h0);
      apb(1'b1, `TCC_IDX_IEN, 32'h01);
      apb(1'b1, `TCC_IDX_SYSCTL, 32'h80);
      for (int k = 0; k < 4; k++)
      begin
         apb(1'b1, `TCC_IDX_ACT30, (k == 3) ? 1 : k + 1);
         chk(pinOe[0], 1'b1);
         hit(8'h01, 8'h00);
         chk(pinOut[0], k[0] ? 1'b0 : 1'b1);
      end
      chk(irq, 8'h01);
      apb(1'b1, `TCC_IDX_SYSCTL, 32'h90);
      apb(1'b1, `TCC_IDX_CC_LO, 32'h0);
      chk(irq, 8'h00);
      // Forced toggle sets no flag; channel 7 override then wins the pin
      hit(8'h00, 8'h01);
      chk({irq[0], pinOut[0]}, 2'b01);
      apb(1'b1, `TCC_IDX_DIR, 32'h81);
      apb(1'b1, `TCC_IDX_MASK7, 32'h01);
      hit(8'h80, 8'h00);
      chk(pinOut[0], 1'b0);
      apb(1'b1, `TCC_IDX_MASK7, 32'h0);
      apb(1'b1, `TCC_IDX_ACT30, 32'h0);
      chk(pinOe[0], 1'b0);
      // Counter load in test mode, then wrap with pin toggle
      testMode <= 1'b1;
      apb(1'b1, `TCC_IDX_SYSCTL, 32'h0);
      apb(1'b1, `TCC_IDX_CNT, 32'hfff0);
      apb(1'b0, `TCC_IDX_CNT, 32'h0);
      chk(rd, 32'hfff0);
      t0 = tickN;
      repeat (130) @(posedge ref_clk);
      chk(tickN - t0, 0);
      apb(1'b0, `TCC_IDX_CNT, 32'h0);
      chk(rd, 32'hfff0);
      apb(1'b1, `TCC_IDX_TOV, 32'h01);
      apb(1'b1, `TCC_IDX_SYSCTL, 32'h80);
      repeat (40) @(posedge ref_clk);
      chk({ovf, pinOut[0]}, 2'b11);
      apb(1'b1, `TCC_IDX_SYSCTL, 32'h90);
      apb(1'b0, `TCC_IDX_CNT, 32'h0);
      chk(ovf, 1'b0);
      a = rd;
      apb(1'b0, `TCC_IDX_CNT, 32'h0);
      chk(rd - a, 3);
      t0 = tickN;
      repeat (128) @(posedge ref_clk);
      chk(tickN - t0, 2);
      // Freeze and wait halts
      freezeMode <= 1'b1;
      apb(1'b1, `TCC_IDX_SYSCTL, 32'ha0);
      apb(1'b0, `TCC_IDX_CNT, 32'h0);
      a = rd;
      repeat (10) @(posedge ref_clk);
      apb(1'b0, `TCC_IDX_CNT, 32'h0);
      chk({rd, aRun, mRun}, {a, 2'b10});
      freezeMode <= 1'b0;
      waitMode   <= 1'b1;
      apb(1'b1, `TCC_IDX_SYSCTL, 32'hc0);
      apb(1'b0, `TCC_IDX_CNT, 32'h0);
      a = rd;
      apb(1'b0, `TCC_IDX_CNT, 32'h0);
      chk({rd, aRun}, {a, 1'b0});
      waitMode <= 1'b0;
      // Capture edge codes on channel 1
      apb(1'b1, `TCC_IDX_SYSCTL, 32'h90);
      for (int k = 0; k < 4; k++)
      begin
         apb(1'b1, `TCC_IDX_EDG30, k << 2);
         t0 = edgeN;
         ext <= 8'h02;
         repeat (6) @(posedge ref_clk);
         ext <= 8'h00;
         repeat (6) @(posedge ref_clk);
         chk(edgeN - t0, (k == 3) ? 2 : (k != 0));
      end
      // Captured flag reaches irq once enabled, write-one clears it
      apb(1'b1, `TCC_IDX_IEN, 32'h02);
      chk(irq, 8'h02);
      apb(1'b1, `TCC_IDX_CFLG, 32'h02);
      chk(irq, 8'h00);
      t0 = clrN;
      apb(1'b0, `TCC_IDX_PC3, 32'h0);
      repeat (2) @(posedge ref_clk);
      chk(clrN - t0, 1);
      report_and_stop;
   end
endmodule : tcc_top_bench
